// ===== hdl/actuator_control_map.vh
// control table addresses, power-on values, write bounds and timing
// assumes inclusion by bare name from the control table module
`ifndef ACTUATOR_CONTROL_MAP_VH
`define ACTUATOR_CONTROL_MAP_VH
// ==================================================
// addresses
`define A_NODE_ID 8'h03
`define A_LINK_DIV 8'h04
`define A_REPLY_DLY 8'h05
`define A_CW_LIM 8'h06
`define A_CCW_LIM 8'h08
`define A_TEMP_CEIL 8'h0b
`define A_VOLT_FLOOR 8'h0c
`define A_VOLT_CEIL 8'h0d
`define A_NV_TORQUE 8'h0e
`define A_REPLY_LVL 8'h10
`define A_LED_MASK 8'h11
`define A_SHUT_MASK 8'h12
`define A_RSVD_13 8'h13
`define A_TRIM 8'h14
`define A_DRIVE_ON 8'h18
`define A_LAMP 8'h19
`define A_CW_BAND 8'h1a
`define A_CCW_BAND 8'h1b
`define A_CW_SLOPE 8'h1c
`define A_CCW_SLOPE 8'h1d
`define A_GOAL 8'h1e
`define A_SPEED 8'h20
`define A_TORQUE 8'h22
`define A_POS 8'h24
`define A_VEL 8'h26
`define A_LOAD 8'h28
`define A_SUPPLY 8'h2a
`define A_TEMP 8'h2b
`define A_PENDING 8'h2c
`define A_MOVING 8'h2e
`define A_GUARD 8'h2f
`define A_PUNCH 8'h30
// ==================================================
// power-on and factory values
`define D_NODE_ID 8'h01
`define D_LINK_DIV 8'h01
`define D_REPLY_DLY 8'hfa
`define D_CW_LIM 10'h000
`define D_CCW_LIM 10'h3ff
`define D_TEMP_CEIL 8'h55
`define D_VOLT_FLOOR 8'h3c
`define D_VOLT_CEIL 8'hbe
`define D_NV_TORQUE 10'h3ff
`define D_REPLY_LVL 2'h2
`define D_ALARM_MASK 7'h04
`define D_SLOPE 8'h20
`define D_PUNCH 10'h020
// ==================================================
// write bounds
`define MAX_NODE_ID 16'h00fd
`define MAX_BYTE 16'h00fe
`define MAX_WORD 16'h03ff
`define MAX_SPEED_WHEEL 16'h07ff
`define MAX_TEMP 16'h0096
`define MIN_VOLT 16'h0032
`define MAX_VOLT 16'h00fa
`define MAX_LEVEL 16'h0002
`define MAX_MASK 16'h007f
`define ALL_NODES 8'hfe
// ==================================================
// error byte bit positions and speed direction bit
`define E_VOLT 0
`define E_ANGLE 1
`define E_HEAT 2
`define E_RANGE 3
`define E_CSUM 4
`define E_LOAD 5
`define E_INSTR 6
`define DIR_BIT 10
// ==================================================
// timing
`define REPLY_UNIT_NS 2000
`define BLINK_HOLD_MS 2000
`define BLINK_HALF_MS 250
`endif

// ===== hdl/actuator_control_table.v
// control table of a networked servo actuator: storage, write checks,
// reply gating and delay, alarm handling and the decoded drive outputs.
// assumes an outside packet decoder that presents one write or one
// read at a time, synchronous to clock_i, and sensors already digitised.
`include "actuator_control_map.vh"

module actuator_control_table #(
    parameter CLOCK_HZ = 10000000,
    parameter HOLD_CYCLES = (CLOCK_HZ / 1000) * `BLINK_HOLD_MS,
    parameter BLINK_CYCLES = (CLOCK_HZ / 1000) * `BLINK_HALF_MS
) (
    input wire clock_i,
    input wire sys_rst_i,
    input wire factory_load_i,
    input wire wr_i,
    input wire deferred_i,
    input wire commit_i,
    input wire [7:0] wr_addr_i,
    input wire [15:0] wr_data_i,
    input wire [7:0] rd_addr_i,
    output reg [7:0] rd_data_o,
    input wire pkt_done_i,
    input wire pkt_read_i,
    input wire [7:0] pkt_dest_i,
    output reg reply_start_o,
    input wire instr_err_i,
    input wire overload_err_i,
    input wire checksum_err_i,
    input wire [9:0] angle_i,
    input wire [10:0] velocity_i,
    input wire [10:0] load_i,
    input wire [7:0] supply_i,
    input wire [7:0] temperature_i,
    input wire moving_i,
    input wire [31:0] trim_i,
    output wire [7:0] error_byte_o,
    output reg [7:0] node_id_o,
    output reg [7:0] link_div_o,
    output wire torque_on_o,
    output wire [9:0] torque_ceiling_o,
    output wire [9:0] goal_o,
    output wire [9:0] speed_o,
    output wire speed_free_o,
    output wire wheel_mode_o,
    output wire turn_cw_o,
    output wire [9:0] punch_o,
    output wire lamp_o
);
    // ==================================================
    // timing counts
    localparam [31:0] UNIT_CYCLES =
        (CLOCK_HZ / 1000 * `REPLY_UNIT_NS + 999999) / 1000000;
    localparam [31:0] HOLD_N = HOLD_CYCLES;
    localparam [31:0] BLINK_N = BLINK_CYCLES;
    localparam [7:0] UNIT_N = UNIT_CYCLES[7:0];

    // ==================================================
    // storage
    reg [7:0] reply_delay, temperature_ceiling;
    reg [7:0] voltage_floor, voltage_ceiling;
    reg [9:0] cw_position_limit, ccw_position_limit;
    reg [9:0] stored_torque_ceiling;
    reg [1:0] reply_level;
    reg [6:0] led_alarm_mask, shutdown_alarm_mask;
    reg reserved_byte_13;
    reg drive_on, indicator_lamp, deferred_write_pending, write_guard;
    reg [7:0] cw_dead_band, ccw_dead_band, cw_gain_slope, ccw_gain_slope;
    reg [9:0] target_angle, active_torque_ceiling, minimum_drive_current;
    reg [10:0] target_velocity;
    reg power_on_copy, range_error, motion_active;
    reg [7:0] held_addr;
    reg [15:0] held_data;

    // ==================================================
    // write path: direct write or committed deferred write
    wire direct = wr_i & ~deferred_i;
    wire apply = direct | (commit_i & deferred_write_pending);
    wire [7:0] w_addr = direct ? wr_addr_i : held_addr;
    wire [15:0] w_data = direct ? wr_data_i : held_data;
    wire wheel_mode = (cw_position_limit == 10'h000) &&
        (ccw_position_limit == 10'h000);
    reg in_bounds;

    // per-register bounds; others refused
    always @* begin
        in_bounds = 1'b0;
        case (w_addr)
            `A_NODE_ID: in_bounds = w_data <= `MAX_NODE_ID;
            `A_LINK_DIV, `A_REPLY_DLY, `A_CW_BAND, `A_CCW_BAND:
                in_bounds = w_data <= `MAX_BYTE;
            `A_CW_LIM, `A_CCW_LIM, `A_NV_TORQUE, `A_GOAL, `A_TORQUE, `A_PUNCH:
                in_bounds = w_data <= `MAX_WORD;
            `A_SPEED: in_bounds = w_data <=
                (wheel_mode ? `MAX_SPEED_WHEEL : `MAX_WORD);
            `A_TEMP_CEIL: in_bounds = w_data <= `MAX_TEMP;
            `A_VOLT_FLOOR, `A_VOLT_CEIL:
                in_bounds = (w_data >= `MIN_VOLT) && (w_data <= `MAX_VOLT);
            `A_REPLY_LVL: in_bounds = w_data <= `MAX_LEVEL;
            `A_LED_MASK, `A_SHUT_MASK:
                in_bounds = w_data <= `MAX_MASK;
            `A_CW_SLOPE, `A_CCW_SLOPE:
                in_bounds = (w_data >= 16'h0001) && (w_data <= `MAX_BYTE);
            `A_RSVD_13, `A_DRIVE_ON, `A_LAMP, `A_PENDING:
                in_bounds = w_data <= 16'h0001;
            `A_GUARD: in_bounds = w_data == 16'h0001;
            default: in_bounds = 1'b0;
        endcase
    end

    // while guarded only the drive block is writable
    wire guard_ok = ~write_guard ||
        ((w_addr >= `A_DRIVE_ON) && (w_addr <= `A_TORQUE + 8'h01));
    wire accept = apply & in_bounds & guard_ok;

    // ==================================================
    // error conditions, recomputed every cycle except range error, held from the last write
    wire heat_err = temperature_i > temperature_ceiling;
    wire volt_err = (supply_i < voltage_floor) ||
        (supply_i > voltage_ceiling);
    wire angle_err = ~wheel_mode &&
        ((target_angle < cw_position_limit) ||
         (target_angle > ccw_position_limit));
    wire [6:0] errors;
    assign errors[`E_VOLT] = volt_err;
    assign errors[`E_ANGLE] = angle_err;
    assign errors[`E_HEAT] = heat_err;
    assign errors[`E_RANGE] = range_error;
    assign errors[`E_CSUM] = checksum_err_i;
    assign errors[`E_LOAD] = overload_err_i;
    assign errors[`E_INSTR] = instr_err_i;
    assign error_byte_o = {1'b0, errors};

    wire led_hit = |(errors & led_alarm_mask);
    wire shut_hit = |(errors & shutdown_alarm_mask);
    reg shut_seen;
    wire shut_rise = shut_hit & ~shut_seen;

    // ==================================================
    // nonvolatile area: survives sys_rst_i, restored by factory load
    always @(posedge clock_i) begin
        if (factory_load_i) begin
            node_id_o <= `D_NODE_ID;
            link_div_o <= `D_LINK_DIV;
            reply_delay <= `D_REPLY_DLY;
            cw_position_limit <= `D_CW_LIM;
            ccw_position_limit <= `D_CCW_LIM;
            temperature_ceiling <= `D_TEMP_CEIL;
            voltage_floor <= `D_VOLT_FLOOR;
            voltage_ceiling <= `D_VOLT_CEIL;
            stored_torque_ceiling <= `D_NV_TORQUE;
            reply_level <= `D_REPLY_LVL;
            led_alarm_mask <= `D_ALARM_MASK;
            shutdown_alarm_mask <= `D_ALARM_MASK;
            reserved_byte_13 <= 1'b0;
        end else if (accept) begin
            case (w_addr)
                `A_NODE_ID: node_id_o <= w_data[7:0];
                `A_LINK_DIV: link_div_o <= w_data[7:0];
                `A_REPLY_DLY: reply_delay <= w_data[7:0];
                `A_CW_LIM: cw_position_limit <= w_data[9:0];
                `A_CCW_LIM: ccw_position_limit <= w_data[9:0];
                `A_TEMP_CEIL: temperature_ceiling <= w_data[7:0];
                `A_VOLT_FLOOR: voltage_floor <= w_data[7:0];
                `A_VOLT_CEIL: voltage_ceiling <= w_data[7:0];
                `A_NV_TORQUE: stored_torque_ceiling <= w_data[9:0];
                `A_REPLY_LVL: reply_level <= w_data[1:0];
                `A_LED_MASK: led_alarm_mask <= w_data[6:0];
                `A_SHUT_MASK: shutdown_alarm_mask <= w_data[6:0];
                `A_RSVD_13: reserved_byte_13 <= w_data[0];
                default: reserved_byte_13 <= reserved_byte_13;
            endcase
        end
    end

    // ==================================================
    // volatile area: power-on defaults, then writes
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            drive_on <= 1'b0;
            indicator_lamp <= 1'b0;
            cw_dead_band <= 8'h00;
            ccw_dead_band <= 8'h00;
            cw_gain_slope <= `D_SLOPE;
            ccw_gain_slope <= `D_SLOPE;
            target_angle <= 10'h000;
            target_velocity <= 11'h000;
            active_torque_ceiling <= 10'h000;
            minimum_drive_current <= `D_PUNCH;
            deferred_write_pending <= 1'b0;
            write_guard <= 1'b0;
            power_on_copy <= 1'b1;
            held_addr <= 8'h00;
            held_data <= 16'h0000;
            shut_seen <= 1'b0;
            range_error <= 1'b0;
            motion_active <= 1'b0;
        end else begin
            shut_seen <= shut_hit;
            motion_active <= moving_i;
            // refused write sets range error
            if (apply & ~accept)
                range_error <= 1'b1;
            else if (accept)
                range_error <= 1'b0;
            if (power_on_copy) begin
                // first edge after release: power-on copy
                power_on_copy <= 1'b0;
                active_torque_ceiling <= stored_torque_ceiling;
                target_angle <= angle_i;
            end else if (accept) begin
                case (w_addr)
                    `A_DRIVE_ON: drive_on <= w_data[0];
                    `A_LAMP: indicator_lamp <= w_data[0];
                    `A_CW_BAND: cw_dead_band <= w_data[7:0];
                    `A_CCW_BAND: ccw_dead_band <= w_data[7:0];
                    `A_CW_SLOPE: cw_gain_slope <= w_data[7:0];
                    `A_CCW_SLOPE: ccw_gain_slope <= w_data[7:0];
                    `A_GOAL: target_angle <= w_data[9:0];
                    `A_SPEED: target_velocity <= w_data[10:0];
                    `A_TORQUE: active_torque_ceiling <= w_data[9:0];
                    `A_PUNCH: minimum_drive_current <= w_data[9:0];
                    `A_GUARD: write_guard <= 1'b1;
                    default: held_addr <= held_addr;
                endcase
            end
            // masked error edge beats a same-cycle enable write
            if (shut_rise)
                drive_on <= 1'b0;
            // deferred write: store, run on commit
            if (wr_i & deferred_i) begin
                held_addr <= wr_addr_i;
                held_data <= wr_data_i;
                deferred_write_pending <= 1'b1;
            end else if (commit_i & deferred_write_pending) begin
                deferred_write_pending <= 1'b0;
            end else if (accept && w_addr == `A_PENDING) begin
                deferred_write_pending <= w_data[0];
            end
        end
    end

    // ==================================================
    // reply gating and delay
    reg [7:0] unit_left;
    reg [7:0] tick_left;
    reg waiting;
    wire want_reply = (pkt_dest_i != `ALL_NODES) &&
        ((reply_level == 2'h2) ||
         (reply_level == 2'h1 && pkt_read_i));

    // counts delay units of UNIT_N cycles each; delay 0 replies at once
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            waiting <= 1'b0;
            unit_left <= 8'h00;
            tick_left <= 8'h00;
            reply_start_o <= 1'b0;
        end else begin
            reply_start_o <= 1'b0;
            if (pkt_done_i) begin
                waiting <= want_reply;
                unit_left <= reply_delay;
                tick_left <= UNIT_N - 8'h01;
            end else if (waiting) begin
                if (unit_left == 8'h00) begin
                    waiting <= 1'b0;
                    reply_start_o <= 1'b1;
                end else if (tick_left == 8'h00) begin
                    tick_left <= UNIT_N - 8'h01;
                    unit_left <= unit_left - 8'h01;
                end else begin
                    tick_left <= tick_left - 8'h01;
                end
            end
        end
    end

    // ==================================================
    // alarm blinking with hold after errors clear
    reg [31:0] hold_left;
    reg [31:0] blink_left;
    reg blink_phase;
    wire blinking = led_hit || (hold_left != 32'h0);

    // hold restarts while active, so ends HOLD_N after clearing
    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_left <= 32'h0;
            blink_left <= 32'h0;
            blink_phase <= 1'b0;
        end else begin
            if (led_hit)
                hold_left <= HOLD_N;
            else if (hold_left != 32'h0)
                hold_left <= hold_left - 32'h1;
            if (!blinking) begin
                blink_left <= 32'h0;
                blink_phase <= 1'b0;
            end else if (blink_left == 32'h0) begin
                blink_left <= BLINK_N - 32'h1;
                blink_phase <= ~blink_phase;
            end else begin
                blink_left <= blink_left - 32'h1;
            end
        end
    end

    // ==================================================
    // decoded drive outputs
    assign lamp_o = blinking ? blink_phase : indicator_lamp;
    assign torque_on_o = drive_on;
    assign torque_ceiling_o = active_torque_ceiling;
    assign goal_o = target_angle;
    assign speed_o = target_velocity[9:0];
    assign speed_free_o = target_velocity[9:0] == 10'h000;
    assign wheel_mode_o = wheel_mode;
    assign turn_cw_o = wheel_mode & target_velocity[`DIR_BIT];
    assign punch_o = minimum_drive_current;

    // ==================================================
    // read port, one cycle latency; unmapped bytes read zero
    wire [15:0] load_word = {5'h00, load_i};
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        case (rd_addr_i)
            `A_NODE_ID: rd_byte = node_id_o;
            `A_LINK_DIV: rd_byte = link_div_o;
            `A_REPLY_DLY: rd_byte = reply_delay;
            `A_CW_LIM: rd_byte = cw_position_limit[7:0];
            `A_CW_LIM + 8'h01: rd_byte = {6'h00, cw_position_limit[9:8]};
            `A_CCW_LIM: rd_byte = ccw_position_limit[7:0];
            `A_CCW_LIM + 8'h01: rd_byte = {6'h00, ccw_position_limit[9:8]};
            `A_TEMP_CEIL: rd_byte = temperature_ceiling;
            `A_VOLT_FLOOR: rd_byte = voltage_floor;
            `A_VOLT_CEIL: rd_byte = voltage_ceiling;
            `A_NV_TORQUE: rd_byte = stored_torque_ceiling[7:0];
            `A_NV_TORQUE + 8'h01:
                rd_byte = {6'h00, stored_torque_ceiling[9:8]};
            `A_REPLY_LVL: rd_byte = {6'h00, reply_level};
            `A_LED_MASK: rd_byte = {1'b0, led_alarm_mask};
            `A_SHUT_MASK: rd_byte = {1'b0, shutdown_alarm_mask};
            `A_RSVD_13: rd_byte = {7'h00, reserved_byte_13};
            `A_TRIM: rd_byte = trim_i[7:0];
            `A_TRIM + 8'h01: rd_byte = trim_i[15:8];
            `A_TRIM + 8'h02: rd_byte = trim_i[23:16];
            `A_TRIM + 8'h03: rd_byte = trim_i[31:24];
            `A_DRIVE_ON: rd_byte = {7'h00, drive_on};
            `A_LAMP: rd_byte = {7'h00, indicator_lamp};
            `A_CW_BAND: rd_byte = cw_dead_band;
            `A_CCW_BAND: rd_byte = ccw_dead_band;
            `A_CW_SLOPE: rd_byte = cw_gain_slope;
            `A_CCW_SLOPE: rd_byte = ccw_gain_slope;
            `A_GOAL: rd_byte = target_angle[7:0];
            `A_GOAL + 8'h01: rd_byte = {6'h00, target_angle[9:8]};
            `A_SPEED: rd_byte = target_velocity[7:0];
            `A_SPEED + 8'h01: rd_byte = {5'h00, target_velocity[10:8]};
            `A_TORQUE: rd_byte = active_torque_ceiling[7:0];
            `A_TORQUE + 8'h01:
                rd_byte = {6'h00, active_torque_ceiling[9:8]};
            `A_POS: rd_byte = angle_i[7:0];
            `A_POS + 8'h01: rd_byte = {6'h00, angle_i[9:8]};
            `A_VEL: rd_byte = velocity_i[7:0];
            `A_VEL + 8'h01: rd_byte = {5'h00, velocity_i[10:8]};
            `A_LOAD: rd_byte = load_word[7:0];
            `A_LOAD + 8'h01: rd_byte = load_word[15:8];
            `A_SUPPLY: rd_byte = supply_i;
            `A_TEMP: rd_byte = temperature_i;
            `A_PENDING: rd_byte = {7'h00, deferred_write_pending};
            `A_MOVING: rd_byte = {7'h00, motion_active};
            `A_GUARD: rd_byte = {7'h00, write_guard};
            `A_PUNCH: rd_byte = minimum_drive_current[7:0];
            `A_PUNCH + 8'h01:
                rd_byte = {6'h00, minimum_drive_current[9:8]};
            default: rd_byte = 8'h00;
        endcase
    end

    always @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            rd_data_o <= 8'h00;
        else
            rd_data_o <= rd_byte;
    end
endmodule

// ===== testbench/actuator_control_table_checker.sv
// checker for the control table ports, attached by bind below
// assumes one clock domain and the table's own port names
module actuator_control_table_checker (
    input wire clock_i, input wire sys_rst_i,
    input wire wr_i, input wire deferred_i,
    input wire [7:0] wr_addr_i, input wire [15:0] wr_data_i,
    input wire [7:0] rd_addr_i, input wire [7:0] rd_data_o,
    input wire pkt_done_i, input wire [7:0] pkt_dest_i,
    input wire reply_start_o, input wire [7:0] temperature_i,
    input wire [7:0] error_byte_o, input wire torque_on_o,
    input wire [9:0] goal_o, input wire wheel_mode_o, input wire turn_cw_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // ==================================================
    // skip the dropped power-on copy edge
    sequence s_take;
        wr_i && !deferred_i && !$past(sys_rst_i);
    endsequence
    sequence s_bcast;
        pkt_done_i && pkt_dest_i == 8'hfe;
    endsequence
    sequence s_calm;
        !pkt_done_i [*2];
    endsequence
    a_reply_pulse: assert property (
        reply_start_o |=> !reply_start_o) else $error("reply too long");
    a_no_bcast: assert property (
        s_bcast ##1 s_calm |-> !reply_start_o && !$past(reply_start_o))
        else $error("reply to all nodes");
    a_trim_refused: assert property (
        s_take ##0 wr_addr_i[7:2] == 6'h05 |=> error_byte_o[3])
        else $error("trim write taken");
    a_drive_enable: assert property (
        s_take ##0 (wr_addr_i == 8'h18 && wr_data_i == 16'h0001
        && error_byte_o == 8'h00) |=> torque_on_o)
        else $error("enable lost");
    a_goal_code: assert property (
        s_take ##0 (wr_addr_i == 8'h1e && wr_data_i <= 16'h03ff)
        |=> {6'h00, goal_o} == $past(wr_data_i)) else $error("goal bad");
    a_temp_read: assert property (
        rd_addr_i == 8'h2b |=> rd_data_o == $past(temperature_i))
        else $error("temperature read bad");
    a_power_off: assert property (
        $fell(sys_rst_i) |-> !torque_on_o) else $error("torque at power-on");
    a_top_bit: assert property (
        error_byte_o[7] == 1'b0) else $error("error bit 7 set");
    a_wheel_dir: assert property (
        turn_cw_o |-> wheel_mode_o) else $error("direction outside wheel");
endmodule
bind actuator_control_table actuator_control_table_checker chk (
    .clock_i, .sys_rst_i, .wr_i, .deferred_i, .wr_addr_i, .wr_data_i,
    .rd_addr_i, .rd_data_o, .pkt_done_i, .pkt_dest_i, .reply_start_o,
    .temperature_i, .error_byte_o, .torque_on_o, .goal_o, .wheel_mode_o,
    .turn_cw_o);

// ===== testbench/actuator_control_table_tb.sv
// self-checking bench for the control table against a register model
// assumes the checker binds itself and the host model drives packets
module actuator_control_table_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 0, sys_rst_i = 1, factory_load_i = 0, wr_i = 0;
    logic deferred_i = 0, commit_i = 0, moving_i = 0, instr_err_i = 0;
    logic overload_err_i = 0, checksum_err_i = 0;
    logic [7:0] wr_addr_i = 0, rd_addr_i = 0, rv;
    logic [7:0] supply_i = 8'h64, temperature_i = 8'h20;
    logic [15:0] wr_data_i = 0;
    logic [9:0] angle_i = 0;
    logic [10:0] velocity_i = 0, load_i = 0;
    logic [31:0] trim_i = 0;
    logic [23:0] bad [7] = '{24'h100003, 24'h0300fe, 24'h1c0000,
        24'h2f0000, 24'h2d0000, 24'h110080, 24'h050100};
    wire [7:0] rd_data_o, error_byte_o, node_id_o, link_div_o, pkt_dest_i;
    wire [9:0] torque_ceiling_o, goal_o, speed_o, punch_o;
    wire reply_start_o, torque_on_o, speed_free_o, wheel_mode_o, turn_cw_o;
    wire lamp_o, pkt_done_i, pkt_read_i;
    int fail_count = 0, num_checks = 0, seed = 32'hd9939259, lat;
    int mdl [0:63];
    bit rng, lock;
    always #50 clock_i = ~clock_i;
    // short alarm hold fits the run
    actuator_control_table #(.HOLD_CYCLES(50), .BLINK_CYCLES(5)) dut (
        .clock_i, .sys_rst_i, .factory_load_i, .wr_i, .deferred_i,
        .commit_i, .wr_addr_i, .wr_data_i, .rd_addr_i, .rd_data_o,
        .pkt_done_i, .pkt_read_i, .pkt_dest_i, .reply_start_o,
        .instr_err_i, .overload_err_i, .checksum_err_i, .angle_i,
        .velocity_i, .load_i, .supply_i, .temperature_i, .moving_i,
        .trim_i, .error_byte_o, .node_id_o, .link_div_o, .torque_on_o,
        .torque_ceiling_o, .goal_o, .speed_o, .speed_free_o,
        .wheel_mode_o, .turn_cw_o, .punch_o, .lamp_o);
    host_model host (.clock_i, .reply_start_o, .pkt_done_i, .pkt_read_i,
        .pkt_dest_i);
    // ==================================================
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value at %0t: %h not %h", $time, s, e);
        end
    endtask
    // model bounds and guard
    function automatic bit ok(int a, int d);
        int hi;
        case (a)
            8'h03: hi = 253;
            8'h10: hi = 2;
            8'h11, 8'h12: hi = 127;
            8'h18, 8'h19, 8'h2f: hi = 1;
            8'h06, 8'h08, 8'h0e, 8'h1e, 8'h22, 8'h30: hi = 1023;
            8'h20: hi = (mdl[6] == 0 && mdl[8] == 0) ? 2047 : 1023;
            8'h04, 8'h05, 8'h1a, 8'h1b, 8'h1c, 8'h1d: hi = 254;
            default: hi = -1;
        endcase
        if (lock && (a < 8'h18 || a > 8'h23)) hi = -1;
        if (d == 0 && (a == 8'h1c || a == 8'h1d || a == 8'h2f)) hi = -1;
        return d <= hi;
    endfunction
    // range flag checked unless deferred
    task wr(input logic [7:0] a, input logic [15:0] d, input bit df = 0);
        @(posedge clock_i);
        wr_i <= 1'b1;
        deferred_i <= df;
        wr_addr_i <= a;
        wr_data_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
        #1 if (!df) begin
            rng = !ok(a, d);
            if (!rng) mdl[a] = d;
            lock = lock || (a == 8'h2f && !rng);
            chk(error_byte_o[3], rng);
        end
    endtask
    task rd(input logic [7:0] a);
        @(posedge clock_i);
        rd_addr_i <= a;
        @(posedge clock_i);
        #1 rv = rd_data_o;
    endtask
    // cut a hang short
    initial begin
        repeat (5000) @(posedge clock_i);
        fail_count++;
        end_of_test;
    end
    // factory load, then a second power-on
    initial begin
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        factory_load_i <= 1'b1;
        @(posedge clock_i);
        factory_load_i <= 1'b0;
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        trim_i <= $random(seed);
        load_i <= $random(seed);
        angle_i <= $random(seed);
        velocity_i <= $random(seed);
        moving_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        #1 mdl[3] = 1;
        mdl[8] = 1023;
        mdl[30] = angle_i;
        chk(torque_ceiling_o, 16'h03ff);
        chk(torque_on_o, 1'b0);
        chk(punch_o, 16'h0020);
        rd(8'h14);
        chk(rv, trim_i[7:0]);
        rd(8'h29);
        chk(rv, {5'h00, load_i[10:8]});
        rd(8'h2e);
        chk(rv, 8'h01);
        wr(8'h14, 16'h0000);
        wr(8'h05, 16'h0000);
        // reply levels, read flag, destination
        for (int i = 0; i < 12; i++) begin
            wr(8'h10, i % 3);
            host.send(i / 6 ? 8'hfe : 8'h01, i / 3 % 2, lat);
            chk(lat, i < 6 && (i % 3 == 2 || i % 3 == 1 && i / 3 % 2)
                ? 1 : -1);
        end
        wr(8'h05, 16'h0001);
        wr(8'h10, 16'h0002);
        host.send(8'h01, 1'b0, lat);
        chk(lat, 21);
        foreach (bad[i]) wr(bad[i][23:16], bad[i][15:0]);
        rd(8'h10);
        chk(rv, mdl[16]);
        // random goals, narrowed window
        wr(8'h06, 16'h0100);
        repeat (8) begin
            wr(8'h1e, $random(seed) & 16'h07ff);
            chk(goal_o, mdl[30]);
            chk(error_byte_o[1], mdl[30] < mdl[6] || mdl[30] > mdl[8]);
        end
        @(posedge clock_i);
        supply_i <= 8'h20;
        @(posedge clock_i);
        #1 chk(error_byte_o[0], 1'b1);
        // heat over ceiling drops torque until re-enabled
        wr(8'h18, 16'h0001);
        @(posedge clock_i);
        supply_i <= 8'h64;
        temperature_i <= 8'h56;
        @(posedge clock_i);
        #1 chk(error_byte_o[2], 1'b1);
        chk(torque_on_o, 1'b0);
        @(posedge clock_i);
        temperature_i <= 8'h55;
        @(posedge clock_i);
        #1 chk(error_byte_o[2] | torque_on_o, 1'b0);
        wr(8'h18, 16'h0001);
        chk(torque_on_o, 1'b1);
        wr(8'h19, 16'h0001);
        repeat (60) @(posedge clock_i);
        #1 chk(lamp_o, 1'b1);
        wr(8'h1e, 16'h0123, 1'b1);
        rd(8'h2c);
        chk({rv, goal_o}, {8'h01, mdl[30][9:0]});
        @(posedge clock_i);
        commit_i <= 1'b1;
        @(posedge clock_i);
        commit_i <= 1'b0;
        rd(8'h2c);
        chk({rv, goal_o}, {8'h00, 10'h123});
        wr(8'h06, 16'h0000);
        wr(8'h08, 16'h0000);
        wr(8'h20, 16'h0405);
        chk({wheel_mode_o, turn_cw_o, speed_o}, 16'h0c05);
        wr(8'h2f, 16'h0001);
        wr(8'h03, 16'h0005);
        chk(node_id_o, mdl[3]);
        wr(8'h19, 16'h0000);
        chk(lamp_o, 1'b0);
        end_of_test;
    end
endmodule

// ===== testbench/host_model.sv
// host controller model: sends instruction packets, times the reply
// assumes the bench clock and the table's reply pulse
module host_model (
    input wire clock_i,
    input wire reply_start_o,
    output logic pkt_done_i = 1'b0,
    output logic pkt_read_i = 1'b0,
    output logic [7:0] pkt_dest_i = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==================================================
    // one packet; edges to reply, -1 if none
    task send(input logic [7:0] d, input logic r, output int lat);
        @(posedge clock_i);
        pkt_done_i <= 1'b1;
        pkt_dest_i <= d;
        pkt_read_i <= r;
        @(posedge clock_i);
        pkt_done_i <= 1'b0;
        lat = -1;
        for (int n = 1; n < 60 && lat < 0; n++) begin
            @(posedge clock_i);
            #1 if (reply_start_o === 1'b1) lat = n;
        end
    endtask
endmodule
